// File: rtcf_pkg.sv
// Shared constants and types for the alarm and status flag block
package rtcf_pkg;

	// Register offsets on the byte-wide bus
	localparam logic [4:0] OFS_MONTH = 5'h05;
	localparam logic [4:0] OFS_ALM_SEC = 5'h08;
	localparam logic [4:0] OFS_ALM_MIN = 5'h09;
	localparam logic [4:0] OFS_ALM_HOUR = 5'h0a;
	localparam logic [4:0] OFS_ALM_DAY = 5'h0b;
	localparam logic [4:0] OFS_STATUS = 5'h0e;
	localparam logic [4:0] OFS_CTRL = 5'h0f;

	// Month and oscillator control byte
	localparam int B_OSC_HALT = 7;
	localparam int B_CLKOUT_OFF = 6;
	localparam int B_BACKUP_CLK = 5;

	// Alarm bytes: mask in bit 7, weekday select in bit 6 of the day byte
	localparam int B_MASK = 7;
	localparam int B_WEEKDAY = 6;

	// Status byte
	localparam int B_MAIN_LOW = 7;
	localparam int B_AUX_LOW = 6;
	localparam int B_HOLD = 5;
	localparam int B_HIZ = 4;
	localparam int B_ALARM = 3;
	localparam int B_KICK = 2;
	localparam int B_DOG = 1;
	localparam int B_PEND = 0;

	// Control byte
	localparam int B_TE = 7;
	localparam int B_WAKE = 4;
	localparam int B_AIE = 3;
	localparam int B_KIE = 2;
	localparam int B_DOGE = 1;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] ALM_RST = 8'h00;
	localparam logic [2:0] OSC_RST = 3'h0;

	// Address hold time before a status read counts
	localparam int CLK_PERIOD_NS = 10;
	localparam int STABLE_NS = 15;
	localparam int STABLE_CYC_I = (STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] STABLE_CYC = 2'(STABLE_CYC_I);

	// Current BCD time from the counting chain
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
	} rtcf_time_t;

	// The four alarm bytes as written by software
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
	} rtcf_alarm_t;

	// Synchronised host bus pins
	typedef struct packed {
		logic ce;
		logic oe;
		logic we;
		logic [4:0] addr;
		logic [7:0] data;
	} rtcf_bus_t;

endpackage

// File: rtcf_alarm_cmp.sv
// Alarm compare against the current time under mask control
`timescale 1ns/1ps
module rtcf_alarm_cmp
	import rtcf_pkg::*;
(
	// Alarm setting and time
	input wire rtcf_alarm_t alarm,
	input wire rtcf_time_t now,
	// Result
	output logic match
);

	// Masked-off compare of the BCD value bits
	function automatic logic eq6(input logic [7:0] a, input logic [7:0] b);
		eq6 = (a[5:0] == b[5:0]);
	endfunction

	logic [3:0] masks;
	logic sec_eq;
	logic min_eq;
	logic hour_eq;
	logic dd_eq;
	logic [7:0] dd_sel;

	// Mask bits and per-field equality
	assign masks = {alarm.day[B_MASK], alarm.hour[B_MASK], alarm.min[B_MASK], alarm.sec[B_MASK]};
	assign sec_eq = (alarm.sec[6:0] == now.sec[6:0]);
	assign min_eq = (alarm.min[6:0] == now.min[6:0]);
	assign hour_eq = eq6(alarm.hour, now.hour);
	assign dd_sel = alarm.day[B_WEEKDAY] ? now.day : now.date;
	assign dd_eq = eq6(alarm.day, dd_sel);

	// Alarm rate decode
	always_comb begin
		unique case (masks)
			4'he: match = sec_eq;
			4'hc: match = sec_eq & min_eq;
			4'h8: match = sec_eq & min_eq & hour_eq;
			4'h0: match = sec_eq & min_eq & hour_eq & dd_eq;
			default: match = 1'b1;
		endcase
	end

endmodule // rtcf_alarm_cmp

// File: rtcf_flags.sv
// Alarm match, status flags, power request and clock output logic
`timescale 1ns/1ps
module rtcf_flags
	import rtcf_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host bus pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [4:0] addr,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe,
	// Time chain, same clock
	input wire rtcf_time_t now,
	input wire logic [3:0] month_in,
	input wire logic sec_tick,
	input wire logic kick_event,
	input wire logic dog_timeout,
	// Analog monitors and oscillator pins
	input wire logic main_batt_low_in,
	input wire logic aux_batt_low_in,
	input wire logic aux_battery_in,
	input wire logic power_fail,
	input wire logic osc_32k,
	// Outputs
	output logic oscillator_halt,
	output logic clock_output_pin,
	output logic power_request_n_o,
	output logic power_request_n_oe,
	output logic irq_n
);

	// Two-stage synchronisers for all pins
	rtcf_bus_t bus_m_r;
	rtcf_bus_t bus_r;
	logic [4:0] mon_m_r;
	logic [4:0] mon_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_m_r <= '0;
			bus_r <= '0;
			mon_m_r <= 5'h00;
			mon_r <= 5'h00;
		end else begin
			bus_m_r <= '{ce: ~ce_n, oe: ~oe_n, we: ~we_n, addr: addr, data: dq_i};
			bus_r <= bus_m_r;
			mon_m_r <= {main_batt_low_in, aux_batt_low_in, aux_battery_in, power_fail, osc_32k};
			mon_r <= mon_m_r;
		end
	end

	logic main_low_s;
	logic aux_low_s;
	logic aux_s;
	logic fail_s;
	logic osc_s;
	assign {main_low_s, aux_low_s, aux_s, fail_s, osc_s} = mon_r;

	// Registers
	logic [2:0] osc_ctrl_r;
	rtcf_alarm_t alarm_r;
	logic [7:0] ctrl_r;
	logic hold_r;
	logic hiz_r;
	logic alarm_flag_r;
	logic kick_flag_r;
	logic dog_flag_r;
	logic wr_prev_r;
	logic [4:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic [4:0] addr_prev_r;
	logic [1:0] rd_cnt_r;
	logic rd_qual_r;

	// Bus decode
	logic wr_act;
	logic rd_act;
	logic wr_commit;
	logic addr_same;
	logic rd_status;
	logic rd_clear_w;
	assign wr_act = bus_r.ce & bus_r.we;
	assign rd_act = bus_r.ce & bus_r.oe & ~bus_r.we;
	assign wr_commit = wr_prev_r & ~wr_act;
	assign addr_same = (bus_r.addr == addr_prev_r);
	assign rd_status = rd_act & (bus_r.addr == OFS_STATUS) & addr_same;
	// clear on address change or strobe rise
	assign rd_clear_w = rd_qual_r & ~rd_status;

	// Write strobes per register
	logic wr_month;
	logic wr_status;
	logic wr_ctrl;
	assign wr_month = wr_commit & (wr_addr_r == OFS_MONTH);
	assign wr_status = wr_commit & (wr_addr_r == OFS_STATUS);
	assign wr_ctrl = wr_commit & (wr_addr_r == OFS_CTRL);

	// Control fields
	logic halt_w;
	logic off_w;
	logic bb_w;
	logic te_w;
	logic wake_w;
	assign halt_w = osc_ctrl_r[B_OSC_HALT - B_BACKUP_CLK];
	assign off_w = osc_ctrl_r[B_CLKOUT_OFF - B_BACKUP_CLK];
	assign bb_w = osc_ctrl_r[B_BACKUP_CLK - B_BACKUP_CLK];
	assign te_w = ctrl_r[B_TE];
	assign wake_w = ctrl_r[B_WAKE];

	// Alarm compare, runs on main or battery power alike
	logic match_w;
	rtcf_alarm_cmp u_cmp (
		.alarm(alarm_r),
		.now(now),
		.match(match_w)
	);

	// match event, gated once per second
	logic set_alarm_w;
	assign set_alarm_w = sec_tick & match_w & te_w & ~halt_w;

	// pending as OR of enabled flags
	logic pend_w;
	assign pend_w = (alarm_flag_r & ctrl_r[B_AIE]) | (kick_flag_r & ctrl_r[B_KIE])
		| (dog_flag_r & ctrl_r[B_DOGE]);

	// Next flag values, set wins over clear except for hiz, where the hardware clear wins over a write
	logic alarm_nxt;
	logic kick_nxt;
	logic dog_nxt;
	logic hiz_nxt;
	// cleared by read or write 0
	assign alarm_nxt = set_alarm_w
		| (alarm_flag_r & ~rd_clear_w & ~(wr_status & ~wr_data_r[B_ALARM]));
	assign kick_nxt = kick_event | (wr_status & wr_data_r[B_KICK])
		| (kick_flag_r & ~rd_clear_w & ~wr_status);
	assign dog_nxt = dog_timeout
		| (dog_flag_r & ~rd_clear_w & ~(wr_status & ~wr_data_r[B_DOG]));
	// hardware clear on wake or kick
	assign hiz_nxt = ((alarm_flag_r & wake_w) | kick_flag_r) ? 1'b0
		: (wr_status ? wr_data_r[B_HIZ] : hiz_r);

	// Read data selection
	logic [7:0] status_w;
	logic [7:0] rd_mux;
	assign status_w = {main_low_s, aux_low_s, hold_r, hiz_r,
		alarm_flag_r, kick_flag_r, dog_flag_r, pend_w};
	always_comb begin
		unique case (bus_r.addr)
			OFS_MONTH: rd_mux = {osc_ctrl_r, 1'b0, month_in};
			OFS_ALM_SEC: rd_mux = alarm_r.sec;
			OFS_ALM_MIN: rd_mux = alarm_r.min;
			OFS_ALM_HOUR: rd_mux = alarm_r.hour;
			OFS_ALM_DAY: rd_mux = alarm_r.day;
			OFS_STATUS: rd_mux = status_w;
			OFS_CTRL: rd_mux = ctrl_r;
			default: rd_mux = 8'h00;
		endcase
	end

	// Bus strobe tracking and write capture
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_prev_r <= 1'b0;
			wr_addr_r <= 5'h00;
			wr_data_r <= 8'h00;
			addr_prev_r <= 5'h00;
		end else begin
			wr_prev_r <= wr_act;
			if (wr_act) begin
				wr_addr_r <= bus_r.addr;
				wr_data_r <= bus_r.data;
			end
			addr_prev_r <= bus_r.addr;
		end
	end

	// status read must stand long enough
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_cnt_r <= 2'h0;
			rd_qual_r <= 1'b0;
		end else begin
			rd_cnt_r <= (rd_status && rd_cnt_r != STABLE_CYC) ? rd_cnt_r + 2'h1
				: (rd_status ? rd_cnt_r : 2'h0);
			rd_qual_r <= rd_status & (rd_qual_r | (rd_cnt_r == STABLE_CYC - 2'h1));
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			osc_ctrl_r <= OSC_RST;
			ctrl_r <= CTRL_RST;
			alarm_r <= {4{ALM_RST}};
		end else begin
			if (wr_month) osc_ctrl_r <= wr_data_r[B_OSC_HALT:B_BACKUP_CLK];
			if (wr_ctrl) ctrl_r <= wr_data_r;
			// full alarm bytes keep mask and select
			if (wr_commit && wr_addr_r == OFS_ALM_SEC) alarm_r.sec <= wr_data_r;
			if (wr_commit && wr_addr_r == OFS_ALM_MIN) alarm_r.min <= wr_data_r;
			if (wr_commit && wr_addr_r == OFS_ALM_HOUR) alarm_r.hour <= wr_data_r;
			if (wr_commit && wr_addr_r == OFS_ALM_DAY) alarm_r.day <= wr_data_r;
		end
	end

	// Flags and power controls
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alarm_flag_r <= 1'b0;
			kick_flag_r <= 1'b0;
			dog_flag_r <= 1'b0;
			hiz_r <= 1'b1;
			hold_r <= 1'b0;
		end else begin
			alarm_flag_r <= alarm_nxt;
			kick_flag_r <= kick_nxt;
			dog_flag_r <= dog_nxt;
			hiz_r <= hiz_nxt;
			if (wr_status) hold_r <= wr_data_r[B_HOLD];
		end
	end

	// Clock output enable
	logic clk_en_w;
	assign clk_en_w = ~halt_w & ((~fail_s & ~off_w) | (fail_s & bb_w & aux_s));

	// Registered pin outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dq_o <= 8'h00;
			dq_oe <= 1'b0;
			oscillator_halt <= 1'b0;
			clock_output_pin <= 1'b0;
			power_request_n_o <= 1'b0;
			power_request_n_oe <= 1'b0;
			irq_n <= 1'b1;
		end else begin
			dq_o <= rd_mux;
			dq_oe <= rd_act;
			oscillator_halt <= halt_w;
			clock_output_pin <= osc_s & clk_en_w;
			power_request_n_o <= 1'b0;
			power_request_n_oe <= ~hiz_r & ~(fail_s & ~hold_r);
			irq_n <= ~pend_w;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	alarm_set_a: assert property (set_alarm_w |=> alarm_flag_r)
		else $error("alarm flag not set after match");
	no_te_a: assert property (!alarm_flag_r && !te_w |=> !alarm_flag_r)
		else $error("alarm flag set with transfers off");
	irq_low_a: assert property (pend_w |=> !irq_n)
		else $error("interrupt not driven while pending");
	irq_rel_a: assert property (!pend_w ##1 !pend_w |-> irq_n)
		else $error("interrupt held without pending");
	wake_drive_a: assert property ((alarm_flag_r && wake_w && !fail_s)[*3] |-> power_request_n_oe)
		else $error("power request not driven on wake");
	fail_float_a: assert property (fail_s && !hold_r |=> !power_request_n_oe)
		else $error("power request driven in fail without hold");
	halt_clk_a: assert property (halt_w |=> !clock_output_pin)
		else $error("clock output runs while halted");
	read_clr_a: assert property (rd_clear_w && !set_alarm_w |=> !alarm_flag_r)
		else $error("status read did not clear alarm flag");
	qual_need_a: assert property (rd_clear_w |-> $past(rd_status, 2))
		else $error("flags cleared without held status read");
	dog_set_a: assert property (dog_timeout |=> dog_flag_r)
		else $error("dog flag not set on timeout");
	kick_set_a: assert property (kick_event |=> kick_flag_r)
		else $error("kick flag not set on event");

	alarm_fire_c: cover property (set_alarm_w);
	read_clear_c: cover property (rd_clear_w && alarm_flag_r);
	wake_out_c: cover property (alarm_flag_r && wake_w ##2 power_request_n_oe);
	irq_c: cover property (!irq_n);

endmodule // rtcf_flags

// File: rtcf_host.sv
// Host processor model for the byte-wide register bus
`timescale 1ns/1ps
module rtcf_host (
	// Clock
	input wire logic clock,
	// Bus pins
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [4:0] addr,
	output logic [7:0] dq_i,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe,
	// Read result
	output logic rd_valid,
	output logic [7:0] rd_data
);
	// Idle bus at time zero
	initial begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		addr = 5'h00;
		dq_i = 8'h00;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end

	// Write cycle, data line inverted once released
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		dq_i <= d;
		ce_n <= 1'b0;
		we_n <= 1'b0;
		repeat (4) @(posedge clock);
		ce_n <= 1'b1;
		we_n <= 1'b1;
		repeat (4) @(posedge clock);
		dq_i <= ~d;
		// Let the registered outputs settle before the caller looks
		@(posedge clock);
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clock);
		addr <= a;
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (6) @(posedge clock);
		rd_data <= dq_oe ? dq_o : ~dq_o;
		rd_valid <= 1'b1;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		@(posedge clock);
		rd_valid <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
endmodule // rtcf_host

// File: rtcf_flags_tb.sv
// Self-checking bench for the alarm and status flag block
`timescale 1ns/1ps
module rtcf_flags_tb
	import rtcf_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic osc = 1'b0;
	logic ce_n, oe_n, we_n, dq_oe, rd_valid;
	logic [4:0] addr;
	logic [7:0] dq_i, dq_o, rd_data;
	rtcf_time_t now;
	logic [3:0] month_in;
	logic sec_tick, kick_event, dog_timeout, mlow, alow, aux_on, pfail;
	logic halt, clk_pin, pr_o, pr_oe, irq_n;
	logic [7:0] expq[$];
	logic [31:0] lfsr = 32'h9b82;
	int n_mismatch = 0;
	int n_compared = 0;
	localparam logic [39:0] T = 40'h3015120505;

	// Clock and free oscillator
	always #5 clock = ~clock;
	always #80 osc = ~osc;

	rtcf_flags dut (.clock(clock), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .now(now),
		.month_in(month_in), .sec_tick(sec_tick), .kick_event(kick_event),
		.dog_timeout(dog_timeout), .main_batt_low_in(mlow), .aux_batt_low_in(alow),
		.aux_battery_in(aux_on), .power_fail(pfail), .osc_32k(osc),
		.oscillator_halt(halt), .clock_output_pin(clk_pin), .power_request_n_o(pr_o),
		.power_request_n_oe(pr_oe), .irq_n(irq_n));
	rtcf_host host (.clock(clock), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_data(rd_data));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Note the expected byte, then read it
	task automatic rdx(input logic [4:0] a, input logic [7:0] e);
		expq.push_back(e);
		host.rd(a);
	endtask

	// One-cycle event pulse
	task automatic pulse(input int which);
		@(posedge clock);
		sec_tick <= (which == 0);
		kick_event <= (which == 1);
		dog_timeout <= (which == 2);
		@(posedge clock);
		sec_tick <= 1'b0;
		kick_event <= 1'b0;
		dog_timeout <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// Program alarm, tick once, check pins and status
	task automatic alarm(input logic [3:0] m, input logic dy, input logic [39:0] tm,
		input logic [7:0] s);
		host.wr(OFS_ALM_SEC, {m[0], 7'h30});
		host.wr(OFS_ALM_MIN, {m[1], 7'h15});
		host.wr(OFS_ALM_HOUR, {m[2], 7'h12});
		host.wr(OFS_ALM_DAY, {m[3], dy, 6'h05});
		@(posedge clock);
		now <= tm;
		pulse(0);
		check({7'h0, irq_n}, {7'h0, ~s[0]});
		check({7'h0, pr_oe}, {7'h0, ~s[4]});
		rdx(OFS_STATUS, s);
		check({7'h0, irq_n}, 8'h01);
	endtask

	// Count clock output rises over a window
	task automatic clk_out(input logic e);
		int c = 0;
		logic p;
		p = clk_pin;
		repeat (300) begin
			@(posedge clock);
			c += (clk_pin === 1'b1 && p === 1'b0);
			p = clk_pin;
		end
		check({7'h0, c > 4}, {7'h0, e});
	endtask

	// Compare oldest note with each read result
	always @(posedge clock) begin
		if (rd_valid === 1'b1) begin
			check(rd_data, expq.pop_front());
		end
	end

	// Cut a hang short
	initial begin
		#300000;
		n_mismatch++;
		complete_run();
	end

	// Main sequence
	initial begin
		now = 40'h0;
		month_in = 4'h7;
		{sec_tick, kick_event, dog_timeout, alow, aux_on, pfail} = 6'h00;
		mlow = 1'b1;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rdx(OFS_CTRL, 8'h00);
		rdx(OFS_STATUS, 8'h90);
		rdx(OFS_MONTH, 8'h07);
		rdx(5'h1f, 8'h00);
		lfsr = step(lfsr);
		host.wr(OFS_ALM_SEC, lfsr[7:0]);
		rdx(OFS_ALM_SEC, lfsr[7:0]);
		clk_out(1'b1);
		host.wr(OFS_CTRL, 8'h08);
		alarm(4'hf, 1'b0, T, 8'h90);
		host.wr(OFS_CTRL, 8'h88);
		lfsr = step(lfsr);
		alarm(4'hf, 1'b0, {lfsr, 8'h00}, 8'h99);
		alarm(4'h5, 1'b0, {lfsr, 8'h11}, 8'h99);
		alarm(4'he, 1'b0, 40'h3115120505, 8'h90);
		alarm(4'he, 1'b0, 40'h3016120505, 8'h99);
		alarm(4'hc, 1'b0, 40'h3016120505, 8'h90);
		alarm(4'hc, 1'b0, 40'h3015130505, 8'h99);
		alarm(4'h8, 1'b0, 40'h3015130505, 8'h90);
		alarm(4'h8, 1'b0, 40'h3015120506, 8'h99);
		alarm(4'h0, 1'b0, 40'h3015120506, 8'h90);
		alarm(4'h0, 1'b0, 40'h3015120605, 8'h99);
		alarm(4'h0, 1'b1, 40'h3015120605, 8'h90);
		alarm(4'h0, 1'b1, 40'h3015120506, 8'h99);
		host.wr(OFS_MONTH, 8'h80);
		check({7'h0, halt}, 8'h01);
		alarm(4'hf, 1'b0, T, 8'h90);
		clk_out(1'b0);
		host.wr(OFS_MONTH, 8'h40);
		clk_out(1'b0);
		host.wr(OFS_MONTH, 8'h60);
		{pfail, aux_on} <= 2'b11;
		clk_out(1'b1);
		{pfail, aux_on} <= 2'b00;
		host.wr(OFS_MONTH, 8'h00);
		host.wr(OFS_CTRL, 8'h98);
		alarm(4'hf, 1'b0, T, 8'h89);
		// power fail with and without hold
		pfail <= 1'b1;
		repeat (4) @(posedge clock);
		check({7'h0, pr_oe}, 8'h00);
		host.wr(OFS_STATUS, 8'h20);
		check({7'h0, pr_oe}, 8'h01);
		check({7'h0, pr_o}, 8'h00);
		pfail <= 1'b0;
		host.wr(OFS_STATUS, 8'h10);
		check({7'h0, pr_oe}, 8'h00);
		host.wr(OFS_CTRL, 8'h84);
		pulse(1);
		check({7'h0, irq_n}, 8'h00);
		rdx(OFS_STATUS, 8'h85);
		host.wr(OFS_STATUS, 8'h14);
		rdx(OFS_STATUS, 8'h85);
		host.wr(OFS_STATUS, 8'h10);
		host.wr(OFS_CTRL, 8'h82);
		pulse(2);
		check({7'h0, irq_n}, 8'h00);
		host.wr(OFS_STATUS, 8'h10);
		check({7'h0, irq_n}, 8'h01);
		pulse(2);
		rdx(OFS_STATUS, 8'h93);
		rdx(OFS_STATUS, 8'h90);
		repeat (5) @(posedge clock);
		complete_run();
	end
endmodule // rtcf_flags_tb
